// ==== rxps_pkg.sv ====
package rxps_pkg;
  localparam int NUM_PORTS = 4;
  localparam logic [7:0] STATUS_ONE_OFFSET = 8'h4d;
  localparam logic [7:0] STATUS_ONE_RESET = 8'h00;
  localparam int PORT_NUM_LSB = 6;
  localparam int CRC_FLAG_BIT = 5;
  localparam int LOCK_CHG_BIT = 4;
  localparam int CTRL_ERR_BIT = 3;
  localparam int PARITY_BIT = 2;
  localparam int PASS_BIT = 1;
  localparam int LOCKED_BIT = 0;

  // Per-port event and level inputs from the receiver side
  typedef struct packed {
    logic crc_error;
    logic sequence_error;
    logic any_ctrl_error;
    logic parity_over_limit;
    logic parity_counter_clear;
    logic detail_read;
    logic pass;
    logic locked;
  } rxps_port_in_t;
endpackage

// ==== rxps_status_one.sv ====
`timescale 1ns/1ns
// Functional notes
// - One status copy per port, selected readback
// - Bits 7:6 return selected read port
// - Bit 5 CRC error sticky, clear on read
// - Bit 4 lock change sticky, clear on read
// - Bit 3 sequence error, clear on read
// - Enhanced mode: bit 3 cleared by detail read
// - Bit 2 set when parity exceeds limit
// - Bit 2 cleared only by counter clear
// - Bit 1 shows live pass indication
// - Bit 0 shows live lock state
module rxps_status_one #(
  parameter int PORTS = rxps_pkg::NUM_PORTS
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CE,
  input wire logic [1:0] READ_PORT,
  input wire logic READ_STROBE,
  input wire logic ENH_CTRL_ERR_EN,
  input wire rxps_pkg::rxps_port_in_t [PORTS-1:0] PORT_IN,
  output logic [7:0] READ_DATA
);
  // Receiver levels come from another domain; two flops before use
  logic [PORTS-1:0] lock_s1_reg, lock_s2_reg, lock_prev_reg;
  logic [PORTS-1:0] pass_s1_reg, pass_s2_reg;
  logic [PORTS-1:0] crc_reg, lchg_reg, seq_reg, par_reg;
  logic [PORTS-1:0] crc_next, lchg_next, seq_next, par_next;
  logic [PORTS-1:0] rd_hit, lock_edge, ctrl_set, ctrl_clr;
  logic [7:0] read_next;
  // Named picks of the selected copy; only the chosen port is visible to the host
  logic sel_crc, sel_lchg, sel_ctrl, sel_par, sel_pass, sel_lock;

  genvar g;
  generate
    for (g = 0; g < PORTS; g++) begin : g_port
      assign rd_hit[g] = READ_STROBE && (READ_PORT == 2'(g));
      assign lock_edge[g] = lock_s2_reg[g] ^ lock_prev_reg[g];
      assign ctrl_set[g] = ENH_CTRL_ERR_EN ? PORT_IN[g].any_ctrl_error : PORT_IN[g].sequence_error;
      // Enhanced mode ignores reads of this register for bit 3
      assign ctrl_clr[g] = ENH_CTRL_ERR_EN ? PORT_IN[g].detail_read : rd_hit[g];
      // Set wins over clear in every flag
      assign crc_next[g] = PORT_IN[g].crc_error | (crc_reg[g] & ~rd_hit[g]);
      assign lchg_next[g] = lock_edge[g] | (lchg_reg[g] & ~rd_hit[g]);
      assign seq_next[g] = ctrl_set[g] | (seq_reg[g] & ~ctrl_clr[g]);
      assign par_next[g] = PORT_IN[g].parity_over_limit |
                           (par_reg[g] & ~PORT_IN[g].parity_counter_clear);
    end
  endgenerate

  assign sel_crc = crc_reg[READ_PORT];
  assign sel_lchg = lchg_reg[READ_PORT];
  assign sel_ctrl = seq_reg[READ_PORT];
  assign sel_par = par_reg[READ_PORT];
  // Live bits are the synchronised levels, so they trail the pins by two cycles
  assign sel_pass = pass_s2_reg[READ_PORT];
  assign sel_lock = lock_s2_reg[READ_PORT];
  assign read_next = {READ_PORT, sel_crc, sel_lchg, sel_ctrl, sel_par, sel_pass, sel_lock};

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      lock_s1_reg <= '0;
      lock_s2_reg <= '0;
      lock_prev_reg <= '0;
      pass_s1_reg <= '0;
      pass_s2_reg <= '0;
    end else if (CE) begin
      for (int i = 0; i < PORTS; i++) begin
        lock_s1_reg[i] <= PORT_IN[i].locked;
        pass_s1_reg[i] <= PORT_IN[i].pass;
      end
      lock_s2_reg <= lock_s1_reg;
      pass_s2_reg <= pass_s1_reg;
      lock_prev_reg <= lock_s2_reg;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      crc_reg <= '0;
      lchg_reg <= '0;
      seq_reg <= '0;
      par_reg <= '0;
      READ_DATA <= rxps_pkg::STATUS_ONE_RESET;
    end else if (CE) begin
      crc_reg <= crc_next;
      lchg_reg <= lchg_next;
      seq_reg <= seq_next;
      par_reg <= par_next;
      // Data reflects the flags before the read clears them
      READ_DATA <= read_next;
    end
  end

  property p_crc_clear;
    @(posedge CLK) disable iff (SYS_RST)
    (CE && rd_hit[0] && !PORT_IN[0].crc_error) |=> !crc_reg[0];
  endproperty
  a_crc_clear: assert property (p_crc_clear) else $error("crc flag not cleared by read");

  property p_crc_set;
    @(posedge CLK) disable iff (SYS_RST)
    (CE && PORT_IN[0].crc_error) |=> crc_reg[0];
  endproperty
  a_crc_set: assert property (p_crc_set) else $error("crc event lost");

  property p_lock_chg;
    @(posedge CLK) disable iff (SYS_RST)
    (CE && lock_s2_reg[0] != lock_prev_reg[0]) |=> lchg_reg[0];
  endproperty
  a_lock_chg: assert property (p_lock_chg) else $error("lock change not flagged");

  property p_seq_hold_enh;
    @(posedge CLK) disable iff (SYS_RST)
    (CE && ENH_CTRL_ERR_EN && seq_reg[0] && !PORT_IN[0].detail_read) |=> seq_reg[0];
  endproperty
  a_seq_hold_enh: assert property (p_seq_hold_enh) else $error("ctrl error cleared wrongly");

  property p_seq_clear;
    @(posedge CLK) disable iff (SYS_RST)
    (CE && !ENH_CTRL_ERR_EN && rd_hit[0] && !PORT_IN[0].sequence_error) |=> !seq_reg[0];
  endproperty
  a_seq_clear: assert property (p_seq_clear) else $error("sequence flag not cleared");

  property p_par_hold;
    @(posedge CLK) disable iff (SYS_RST)
    (CE && par_reg[0] && !PORT_IN[0].parity_counter_clear) |=> par_reg[0];
  endproperty
  a_par_hold: assert property (p_par_hold) else $error("parity flag dropped");

  property p_par_set;
    @(posedge CLK) disable iff (SYS_RST)
    (CE && PORT_IN[0].parity_over_limit) |=> par_reg[0];
  endproperty
  a_par_set: assert property (p_par_set) else $error("parity flag not set");

  property p_port_num;
    @(posedge CLK) disable iff (SYS_RST)
    CE |=> READ_DATA[7:6] == $past(READ_PORT);
  endproperty
  a_port_num: assert property (p_port_num) else $error("port number wrong");

  property p_live;
    @(posedge CLK) disable iff (SYS_RST)
    CE |=> READ_DATA[1:0] == {$past(pass_s2_reg[READ_PORT]), $past(lock_s2_reg[READ_PORT])};
  endproperty
  a_live: assert property (p_live) else $error("live bits wrong");

  property p_crc_hold;
    @(posedge CLK) disable iff (SYS_RST)
    (CE && crc_reg[0] && !rd_hit[0]) |=> crc_reg[0];
  endproperty
  a_crc_hold: assert property (p_crc_hold) else $error("crc flag dropped without read");

  sequence s_crc_read;
    CE && rd_hit[0] && crc_reg[0];
  endsequence

  property p_crc_seen;
    @(posedge CLK) disable iff (SYS_RST)
    s_crc_read |=> READ_DATA[5];
  endproperty
  a_crc_seen: assert property (p_crc_seen) else $error("clearing read hid crc flag");

  property p_lchg_clear;
    @(posedge CLK) disable iff (SYS_RST)
    (CE && rd_hit[0] && lock_s2_reg[0] == lock_prev_reg[0]) |=> !lchg_reg[0];
  endproperty
  a_lchg_clear: assert property (p_lchg_clear) else $error("lock change not cleared by read");

  property p_lchg_hold;
    @(posedge CLK) disable iff (SYS_RST)
    (CE && lchg_reg[0] && !rd_hit[0]) |=> lchg_reg[0];
  endproperty
  a_lchg_hold: assert property (p_lchg_hold) else $error("lock change dropped without read");

  sequence s_lchg_read;
    CE && rd_hit[0] && lchg_reg[0];
  endsequence

  property p_lchg_seen;
    @(posedge CLK) disable iff (SYS_RST)
    s_lchg_read |=> READ_DATA[4];
  endproperty
  a_lchg_seen: assert property (p_lchg_seen) else $error("clearing read hid lock change");

  property p_seq_set;
    @(posedge CLK) disable iff (SYS_RST)
    (CE && !ENH_CTRL_ERR_EN && PORT_IN[0].sequence_error) |=> seq_reg[0];
  endproperty
  a_seq_set: assert property (p_seq_set) else $error("sequence error lost");

  property p_seq_hold;
    @(posedge CLK) disable iff (SYS_RST)
    (CE && !ENH_CTRL_ERR_EN && seq_reg[0] && !rd_hit[0]) |=> seq_reg[0];
  endproperty
  a_seq_hold: assert property (p_seq_hold) else $error("sequence flag dropped without read");

  property p_any_set;
    @(posedge CLK) disable iff (SYS_RST)
    (CE && ENH_CTRL_ERR_EN && PORT_IN[0].any_ctrl_error) |=> seq_reg[0];
  endproperty
  a_any_set: assert property (p_any_set) else $error("ctrl error lost");

  property p_any_clear;
    @(posedge CLK) disable iff (SYS_RST)
    (CE && ENH_CTRL_ERR_EN && PORT_IN[0].detail_read && !PORT_IN[0].any_ctrl_error) |=> !seq_reg[0];
  endproperty
  a_any_clear: assert property (p_any_clear) else $error("ctrl error not cleared by detail read");

  property p_par_clear;
    @(posedge CLK) disable iff (SYS_RST)
    (CE && PORT_IN[0].parity_counter_clear && !PORT_IN[0].parity_over_limit) |=> !par_reg[0];
  endproperty
  a_par_clear: assert property (p_par_clear) else $error("parity flag not cleared");

  // Copies are independent: a read of another port must not touch port 1
  property p_copy_apart;
    @(posedge CLK) disable iff (SYS_RST)
    (CE && crc_reg[1] && !(READ_STROBE && READ_PORT == 2'h1)) |=> crc_reg[1];
  endproperty
  a_copy_apart: assert property (p_copy_apart) else $error("other port read cleared flag");

  property p_freeze;
    @(posedge CLK) disable iff (SYS_RST)
    !CE |=> $stable(crc_reg) && $stable(lchg_reg) && $stable(seq_reg) && $stable(par_reg) && $stable(READ_DATA);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while disabled");
endmodule

// ==== rxps_host.sv ====
`timescale 1ns/1ns
module rxps_host (
  input wire logic CLK,
  input wire logic [7:0] READ_DATA,
  output logic [1:0] READ_PORT,
  output logic READ_STROBE
);
  initial begin
    READ_PORT = 2'h0;
    READ_STROBE = 1'b0;
  end
  // Port field moves with the strobe; the pre-clear byte is taken after the strobe edge
  task automatic rd(input logic [1:0] p, output logic [7:0] d);
    @(posedge CLK);
    #1 READ_PORT = p;
    READ_STROBE = 1'b1;
    @(posedge CLK);
    #1 READ_STROBE = 1'b0;
    d = READ_DATA;
  endtask
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
  logic clk = 0, rst = 1, enh = 0, ce = 1;
  logic [7:0] m;
  int r;
  logic [3:0][7:0] pin = '0;
  logic [1:0] rp, q;
  logic rs;
  logic [7:0] rdat, d;
  int n_mismatch = 0, num_checks = 0;
  rxps_status_one DUT (.CLK(clk), .SYS_RST(rst), .CE(ce), .READ_PORT(rp), .READ_STROBE(rs),
    .ENH_CTRL_ERR_EN(enh), .PORT_IN(pin), .READ_DATA(rdat));
  rxps_host host (.CLK(clk), .READ_DATA(rdat), .READ_PORT(rp), .READ_STROBE(rs));
  initial forever #4 clk = ~clk;
  function automatic logic [7:0] e(input logic [1:0] p, input logic [5:0] f);
    return {p, f};
  endfunction
  task automatic chk(input logic [7:0] a, input logic [7:0] b);
    num_checks++;
    if (a !== b) begin
      n_mismatch++;
      $display("BAD t=%0t got %h exp %h", $time, a, b);
    end
  endtask
  task automatic ev(input int p, input logic [7:0] m);
    pin[p] = pin[p] | m;
    @(posedge clk);
    #1 pin[p] = pin[p] & ~m;
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #20000;
    n_mismatch++;
    conclude;
  end
  initial begin
    void'($urandom(32'h3d6bd4fa));
    repeat (12) @(posedge clk);
    #1 rst = 0;
    chk(rdat, 8'h00);
    // All ports lock and see both events before any read, so each copy must stand alone
    pin = {4{8'h01}};
    for (int p = 0; p < 4; p++) ev(p, 8'hc0);
    repeat (6) @(posedge clk);
    for (int p = 0; p < 4; p++) begin
      host.rd(2'(p), d);
      chk(d, e(2'(p), 6'h39));
      host.rd(2'(p), d);
      chk(d, e(2'(p), 6'h01));
    end
    $display("per-port flags done");
    // Event arriving in the very cycle of the clearing read must survive it
    fork
      host.rd(2'h0, d);
      begin
        @(posedge clk);
        #1 ev(0, 8'h80);
      end
    join
    chk(d, e(2'h0, 6'h01));
    host.rd(2'h0, d);
    chk(d, e(2'h0, 6'h21));
    @(posedge clk);
    #1 ce = 0;
    ev(1, 8'h80);
    ce = 1;
    host.rd(2'h1, d);
    chk(d, e(2'h1, 6'h01));
    $display("same-cycle and enable done");
    for (int k = 0; k < 8; k++) begin
      r = $urandom % 4;
      m = 8'($urandom) & 8'hc0;
      ev(r, m);
      host.rd(2'(r), d);
      chk(d, e(2'(r), {m[7], 1'b0, m[6], 3'b001}));
    end
    $display("random events done");
    q = 2'($urandom % 4);
    enh = 1;
    ev(q, 8'h30);
    pin[q][1] = 1'b1;
    repeat (6) @(posedge clk);
    host.rd(q, d);
    host.rd(q, d);
    chk(d, e(q, 6'h0f));
    ev(q, 8'h0c);
    host.rd(q, d);
    chk(d, e(q, 6'h03));
    $display("enhanced and parity done");
    pin[q][1] = 1'b0;
    @(posedge clk);
    #1 rst = 1;
    repeat (2) @(posedge clk);
    #1 rst = 0;
    chk(rdat, 8'h00);
    repeat (6) @(posedge clk);
    host.rd(2'h0, d);
    chk(d, e(2'h0, 6'h11));
    $display("mid-run reset done");
    conclude;
  end
endmodule
